//--- src/sat_pkg.sv
// Package for the split auto-reload timer: register map, fields,
// reset values, divider counts and the state record.
// Assumes one 200 MHz system clock and an 8-bit register port.
package sat_pkg;

    // ----------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h91; // timer_control_register
    localparam logic [7:0] OFF_RLL    = 8'h92; // reload_low_byte
    localparam logic [7:0] OFF_RLH    = 8'h93; // reload_high_byte
    localparam logic [7:0] OFF_CNTL   = 8'h94; // count_low_byte
    localparam logic [7:0] OFF_CNTH   = 8'h95; // count_high_byte
    localparam logic [7:0] OFF_CKCON  = 8'h96; // clock_control_register
    localparam logic [7:0] OFF_IRQEN  = 8'h97; // extended_irq_enable_register
    localparam logic [7:0] OFF_STAT   = 8'h98; // Sticky event status, read only
    localparam logic [7:0] OFF_CLR    = 8'h99; // Event clear, write one to clear

    // ----------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------
    localparam int CTRL_FH    = 7;
    localparam int CTRL_FL    = 6;
    localparam int CTRL_LIE   = 5;
    localparam int CTRL_SPLIT = 3;
    localparam int CTRL_RUN   = 2;
    localparam int CTRL_XCLK  = 0;
    localparam int CK_SELH    = 1;
    localparam int CK_SELL    = 0;
    localparam int IE_TIMER   = 7;
    localparam int ST_HIGH    = 1;
    localparam int ST_LOW     = 0;

    // ----------------------------------------------------------
    // Reset values and divider counts
    // ----------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int         DIV_SYS  = 12;
    localparam int         DIV_EXT  = 8;

    // Whole state of the timer, registered as one record
    typedef struct packed {
        logic       fH;
        logic       fL;
        logic       lowIe;
        logic       split;
        logic       run;
        logic       xclk;
        logic       selH;
        logic       selL;
        logic       timIe;
        logic [7:0] rlL;
        logic [7:0] rlH;
        logic [7:0] cntL;
        logic [7:0] cntH;
        logic [1:0] stat;
        logic [3:0] div12;
        logic [2:0] div8;
        logic       xs1;
        logic       xs2;
        logic       xs3;
        logic [7:0] rdata;
        logic       irq;
    } sat_state_t;

endpackage

//--- src/sat_timer.sv
// Split auto-reload timer: two byte counters, prescalers, the
// register port and the interrupt output.
// Assumes a synchronous single-master register port on clk_sys.
//
// Contract
// [R1] Two byte counters form one 16-bit count; 16-bit or split mode.
// [R2] Sources: system clock, system clock /12, synchronised external /8.
// [R3] Split select zero runs one 16-bit reloading up-counter.
// [R4] 16-bit wrap from all ones loads both reload bytes, sets high flag.
// [R5] 16-bit mode interrupts on each full overflow when timer enable set.
// [R6] 16-bit mode also interrupts on low byte wrap if low enable set.
// [R7] Split select one: two 8-bit timers, each from its reload byte.
// [R8] In split mode run control gates only the high byte.
// [R9] Per-byte select: one is system clock, zero picks /12 or external /8.
// [R10] Split mode sets high or low flag when that byte wraps.
// [R11] Split mode interrupts on high wrap, low wrap too if enabled.
// [R12] Flags are only cleared by a software write of zero.
// [R13] Software reads both flags to find the source and clears them.
// [R14] Split select encodes zero as 16-bit and one as two 8-bit timers.
// [R15] Control: flags 7,6, low enable 5, split 3, run 2, external 0, reset zero.
// [R16] Divided clocks become one-cycle count enables on the system clock.
// [R17] A software write to a count byte beats increment or reload.
`timescale 1ns/1ps

module sat_timer #(
    parameter int DIV_SYS = sat_pkg::DIV_SYS,
    parameter int DIV_EXT = sat_pkg::DIV_EXT
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // External oscillator
    input  wire logic       extClk,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    // Interrupt
    output logic            irq
);

    // ----------------------------------------------------------
    // State and count enables
    // ----------------------------------------------------------
    sat_pkg::sat_state_t s;
    sat_pkg::sat_state_t next_s;

    logic tick12;
    logic tick8;
    logic extEdge;
    logic tickDiv;
    logic tickL;
    logic tickH;

    // Step a byte with auto-reload; bit 8 marks the wrap
    function automatic logic [8:0] bump(input logic [7:0] cnt,
                                        input logic [7:0] rl);
        if (cnt == 8'hff) begin
            return {1'b1, rl};
        end
        return {1'b0, cnt + 8'h01};
    endfunction

    // One-cycle enables from the dividers; no gated clocks anywhere
    assign tick12  = (s.div12 == 4'(DIV_SYS - 1)); // see [R16]
    assign extEdge = s.xs2 & ~s.xs3;             // see [R2]
    assign tick8   = extEdge & (s.div8 == 3'(DIV_EXT - 1)); // see [R16]
    assign tickDiv = s.xclk ? tick8 : tick12;
    assign tickL   = s.selL | tickDiv;           // see [R9]
    assign tickH   = s.selH | tickDiv;           // see [R9]

    assign regRdata = s.rdata;
    assign irq      = s.irq;

    // ----------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------
    always_comb begin
        logic       evH;
        logic       evL;
        logic       wrHit;
        logic [8:0] stepL;
        logic [8:0] stepH;
        logic [7:0] rd;
        evH   = 1'b0;
        evL   = 1'b0;
        wrHit = regWr;
        stepL = bump(s.cntL, s.rlL);
        stepH = bump(s.cntH, s.rlH);
        rd    = 8'h00;
        next_s = s;

        // External input: two flops, third only for the edge
        next_s.xs1 = extClk;
        next_s.xs2 = s.xs1;
        next_s.xs3 = s.xs2;
        next_s.div12 = tick12 ? 4'h0 : s.div12 + 4'h1;
        if (extEdge) begin
            next_s.div8 = tick8 ? 3'h0 : s.div8 + 3'h1;
        end

        if (!s.split) begin
            // One 16-bit counter clocked by the low byte source
            if (s.run && tickL) begin                   // see [R3]
                if ({s.cntH, s.cntL} == 16'hffff) begin
                    next_s.cntL = s.rlL;                // see [R4]
                    next_s.cntH = s.rlH;                // see [R4]
                    evH = 1'b1;
                    evL = 1'b1;
                end else begin
                    next_s.cntL = s.cntL + 8'h01;       // see [R1]
                    if (s.cntL == 8'hff) begin
                        next_s.cntH = s.cntH + 8'h01;
                        evL = 1'b1;                     // see [R6]
                    end
                end
            end
        end else begin
            // Low byte always runs; run control holds the high one
            if (tickL) begin                            // see [R8]
                next_s.cntL = stepL[7:0];               // see [R7]
                evL = stepL[8];                         // see [R10]
            end
            if (s.run && tickH) begin                   // see [R8]
                next_s.cntH = stepH[7:0];               // see [R7]
                evH = stepH[8];                         // see [R10]
            end
        end

        // Flags set here or by a control write of one; software alone clears them
        next_s.fH = s.fH | evH;                         // see [R12]
        next_s.fL = s.fL | evL;                         // see [R12]
        next_s.stat = s.stat | {evH, evL};

        // Writes; an event in the same cycle wins over a clear
        if (wrHit) begin
            unique case (regAddr)
                sat_pkg::OFF_CTRL: begin                // see [R15]
                    next_s.fH    = regWdata[sat_pkg::CTRL_FH] | evH;
                    next_s.fL    = regWdata[sat_pkg::CTRL_FL] | evL;
                    next_s.lowIe = regWdata[sat_pkg::CTRL_LIE];
                    next_s.split = regWdata[sat_pkg::CTRL_SPLIT]; // see [R14]
                    next_s.run   = regWdata[sat_pkg::CTRL_RUN];
                    next_s.xclk  = regWdata[sat_pkg::CTRL_XCLK];
                end
                sat_pkg::OFF_RLL:   next_s.rlL  = regWdata;
                sat_pkg::OFF_RLH:   next_s.rlH  = regWdata;
                sat_pkg::OFF_CNTL:  next_s.cntL = regWdata; // see [R17]
                sat_pkg::OFF_CNTH:  next_s.cntH = regWdata; // see [R17]
                sat_pkg::OFF_CKCON: begin
                    next_s.selH = regWdata[sat_pkg::CK_SELH];
                    next_s.selL = regWdata[sat_pkg::CK_SELL];
                end
                sat_pkg::OFF_IRQEN:
                    next_s.timIe = regWdata[sat_pkg::IE_TIMER];
                sat_pkg::OFF_CLR:
                    next_s.stat = (s.stat & ~regWdata[1:0]) | {evH, evL};
                default: ;
            endcase
        end

        // Read mux; data stand one cycle, zero otherwise
        if (regRd) begin
            unique case (regAddr)
                sat_pkg::OFF_CTRL: begin                // see [R15]
                    rd[sat_pkg::CTRL_FH]    = s.fH;
                    rd[sat_pkg::CTRL_FL]    = s.fL;
                    rd[sat_pkg::CTRL_LIE]   = s.lowIe;
                    rd[sat_pkg::CTRL_SPLIT] = s.split;
                    rd[sat_pkg::CTRL_RUN]   = s.run;
                    rd[sat_pkg::CTRL_XCLK]  = s.xclk;
                end
                sat_pkg::OFF_RLL:   rd = s.rlL;
                sat_pkg::OFF_RLH:   rd = s.rlH;
                sat_pkg::OFF_CNTL:  rd = s.cntL;
                sat_pkg::OFF_CNTH:  rd = s.cntH;
                sat_pkg::OFF_CKCON: begin
                    rd[sat_pkg::CK_SELH] = s.selH;
                    rd[sat_pkg::CK_SELL] = s.selL;
                end
                sat_pkg::OFF_IRQEN: rd[sat_pkg::IE_TIMER] = s.timIe;
                sat_pkg::OFF_STAT:  rd[1:0] = s.stat;
                default:            rd = 8'h00;
            endcase
        end
        next_s.rdata = rd;

        // Level interrupt; low events count only with the low enable
        next_s.irq = next_s.timIe &
                     (next_s.stat[sat_pkg::ST_HIGH] |     // see [R5]
                      (next_s.stat[sat_pkg::ST_LOW] &     // see [R6]
                       next_s.lowIe));                    // see [R11]
    end

    // ----------------------------------------------------------
    // State register
    // ----------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;                                    // see [R15]
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Software overrides in a cycle excuse that cycle from the checks
    logic wrCntL;
    logic wrCntH;
    logic wrCtrl;
    assign wrCntL = regWr && regAddr == sat_pkg::OFF_CNTL;
    assign wrCntH = regWr && regAddr == sat_pkg::OFF_CNTH;
    assign wrCtrl = regWr && regAddr == sat_pkg::OFF_CTRL;

    sequence wrap16_s;
        !s.split && s.run && tickL && {s.cntH, s.cntL} == 16'hffff
        && !wrCntL && !wrCntH && !wrCtrl;
    endsequence

    sequence tick_gap_s;
        tick12 ##1 !tick12 [*8] ##1 !tick12 [*3] ##1 tick12;
    endsequence

    a_wrap_reload: assert property ( // see [R4]
        wrap16_s |=> s.cntL == $past(s.rlL) && s.cntH == $past(s.rlH) && s.fH)
        else $error("16-bit wrap did not reload or flag");

    a_wrap_carry: assert property ( // see [R3]
        !s.split && s.run && tickL && s.cntL == 8'hff && s.cntH != 8'hff
        && !wrCntL && !wrCntH && !wrCtrl
        |=> s.cntL == 8'h00 && s.cntH == $past(s.cntH) + 8'h01)
        else $error("16-bit carry into high byte missing");

    a_div_period: assert property ( // see [R2]
        tick12 |-> tick_gap_s)
        else $error("Divide-by-12 enable period wrong");

    a_low_free: assert property ( // see [R8]
        s.split && !s.run && tickL && s.cntL != 8'hff && !wrCntL
        |=> s.cntL == $past(s.cntL) + 8'h01)
        else $error("Split low byte did not run");

    a_high_held: assert property ( // see [R8]
        s.split && !s.run && !wrCntH |=> $stable(s.cntH))
        else $error("Split high byte moved while stopped");

    a_sys_select: assert property ( // see [R9]
        s.split && s.selL && s.cntL == 8'hff && !wrCntL && !wrCtrl
        |=> s.cntL == $past(s.rlL) && s.fL)
        else $error("Low byte wrap on system clock failed");

    a_flag_sticky: assert property ( // see [R12]
        s.fH && !wrCtrl |=> s.fH)
        else $error("High flag cleared without a write");

    a_wr_priority: assert property ( // see [R17]
        wrCntL |=> s.cntL == $past(regWdata))
        else $error("Count write lost to counting");

    a_irq_high: assert property ( // see [R11]
        s.timIe && $rose(s.stat[sat_pkg::ST_HIGH]) |-> irq)
        else $error("High overflow did not interrupt");

    a_irq_low: assert property ( // see [R6]
        irq && !s.stat[sat_pkg::ST_HIGH] |-> s.lowIe && s.stat[sat_pkg::ST_LOW])
        else $error("Low interrupt without its enable");

    a_low_sticky: assert property ( // see [R12]
        s.fL && !wrCtrl |=> s.fL)
        else $error("Low flag cleared without a write");

    a_read_idle: assert property ( // see [R15]
        !regRd |=> regRdata == 8'h00)
        else $error("Read data not zero outside a read");

    a_split_high_wrap: assert property ( // see [R10]
        s.split && s.run && tickH && s.cntH == 8'hff && !wrCntH && !wrCtrl
        |=> s.cntH == $past(s.rlH) && s.fH)
        else $error("Split high byte wrap did not reload or flag");

    a_stop_hold: assert property ( // see [R3]
        !s.split && !s.run && !wrCntL && !wrCntH |=> $stable({s.cntH, s.cntL}))
        else $error("16-bit count moved while stopped");

    a_irq_enable: assert property ( // see [R5]
        irq |-> s.timIe)
        else $error("Interrupt without timer enable");

    a_low_wrap_flag: assert property ( // see [R6]
        !s.split && s.run && tickL && s.cntL == 8'hff && !wrCtrl
        |=> s.fL)
        else $error("16-bit low byte wrap did not set low flag");

endmodule

//--- sim/testbench.sv
// Self-checking bench for the split auto-reload timer.
// Assumes sat_timer with its internal assertions and the sat_pkg map.
`timescale 1ns/1ps

module testbench;

    // ----------------------------------------------------------
    // Signals and register shortcuts
    // ----------------------------------------------------------
    localparam logic [7:0] CTL = sat_pkg::OFF_CTRL;
    localparam logic [7:0] RLL = sat_pkg::OFF_RLL;
    localparam logic [7:0] RLH = sat_pkg::OFF_RLH;
    localparam logic [7:0] CNL = sat_pkg::OFF_CNTL;
    localparam logic [7:0] CNH = sat_pkg::OFF_CNTH;
    localparam logic [7:0] CKC = sat_pkg::OFF_CKCON;
    localparam logic [7:0] STA = sat_pkg::OFF_STAT;
    localparam logic [7:0] CLR = sat_pkg::OFF_CLR;
    logic       clk_sys = 1'b0;
    logic       reset_n;
    logic       extClk = 1'b0;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdata;
    logic       irq;
    int         bad_count;
    int         check_count;

    sat_timer #(.DIV_SYS(sat_pkg::DIV_SYS), .DIV_EXT(sat_pkg::DIV_EXT)) dut_u (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .extClk  (extClk),
        .regAddr (regAddr),
        .regWdata(regWdata),
        .regWr   (regWr),
        .regRd   (regRd),
        .regRdata(regRdata),
        .irq     (irq)
    );

    // Clocks: external oscillator period is eight system cycles
    always #2.5 clk_sys = ~clk_sys;
    always #20 extClk = ~extClk;

    // ----------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask

    // Range check where the prescaler phase is free running
    task automatic rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("range reg %h", a), 8'h01, {7'h00, (d >= lo) && (d <= hi)});
    endtask

    task automatic ci(input logic e);
        @(posedge clk_sys);
        #1 chk("irq", {7'h00, e}, {7'h00, irq});
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        rc(CTL, 8'h00);
        rc(CNL, 8'h00);
        rc(RLH, 8'h00);
        ci(1'b0);
        wr(8'h00, 8'hff);
        rc(8'h00, 8'h00);
        wr(CTL, 8'hff);
        rc(CTL, 8'hed);
        wr(CTL, 8'h00);
        rc(CLR, 8'h00);
    endtask

    task automatic t_wrap16;
        wr(CKC, 8'h01);
        wr(RLL, 8'h34);
        wr(RLH, 8'h12);
        wr(CNL, 8'hf0);
        wr(CNH, 8'hff);
        wr(sat_pkg::OFF_IRQEN, 8'h80);
        wr(CTL, 8'h04);
        cyc(40);
        rc(CTL, 8'hc4);
        ci(1'b1);
        wr(CTL, 8'hc0);
        rc(CNH, 8'h12);
        cyc(50);
        rc(CTL, 8'hc0);
        wr(CTL, 8'h00);
        rc(STA, 8'h03);
        wr(STA, 8'h00);
        rc(STA, 8'h03);
        wr(CLR, 8'h03);
        cyc(1);
        ci(1'b0);
    endtask

    task automatic t_low16;
        wr(CNL, 8'hf0);
        wr(CNH, 8'h00);
        wr(CTL, 8'h04);
        cyc(30);
        rc(STA, 8'h01);
        ci(1'b0);
        wr(CTL, 8'h24);
        cyc(2);
        ci(1'b1);
        wr(CTL, 8'h00);
        rc(CNH, 8'h01);
        wr(CLR, 8'h03);
    endtask

    task automatic t_split;
        wr(CKC, 8'h03);
        wr(RLL, 8'hf0);
        wr(CNH, 8'h10);
        wr(CTL, 8'h08);
        cyc(300);
        rc(CTL, 8'h48);
        rc(CNH, 8'h10);
        rng(CNL, 8'hf0, 8'hff);
        ci(1'b0);
        wr(CTL, 8'h28);
        cyc(2);
        ci(1'b1);
        wr(RLH, 8'ha5);
        wr(CNH, 8'hfe);
        wr(CTL, 8'h0c);
        cyc(40);
        rc(CTL, 8'hcc);
        wr(CTL, 8'h08);
        rng(CNH, 8'ha5, 8'hd5);
        rc(STA, 8'h03);
        wr(CLR, 8'h03);
        // Low byte ticks every cycle here, so the write meets a due tick
        wr(CNL, 8'h40);
        rc(CNL, 8'h41);
    endtask

    task automatic t_divide;
        wr(CKC, 8'h00);
        wr(CTL, 8'h0c);
        wr(CNH, 8'h00);
        cyc(120);
        rng(CNH, 8'h09, 8'h0b);
        wr(CTL, 8'h0d);
        wr(CNH, 8'h00);
        cyc(320);
        rng(CNH, 8'h04, 8'h06);
        wr(CTL, 8'h00);
    endtask

    // ----------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------------------------
    task automatic end_of_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cuts a hang short after 20000 cycles, well above the test's run length
    initial begin
        cyc(20000);
        bad_count++;
        $display("Error watchdog expected done seen hang");
        end_of_test;
    end

    initial begin
        reset_n  = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
        regWr    = 1'b0;
        regRd    = 1'b0;
        cyc(8);
        reset_n <= 1'b1;
        t_reset;
        t_wrap16;
        t_low16;
        t_split;
        t_divide;
        end_of_test;
    end

endmodule
